// ---- serial_port.sv ----
// Asynchronous serial port with LIN helpers behind an APB slave
//
// Contract
// - Transmitter and receiver run independently, full duplex.
// - One received byte is held while the next frame is received.
// - A new completed frame overwrites the unread received byte.
// - Writing the transmit buffer loads the transmit holding register.
// - Reading the receive buffer returns a separate receive register.
// - Frames carry 8 or 9 data bits, least significant first.
// - One-byte transmit holding buffer loads while a frame shifts out.
// - Fractional baud divider, fixed or programmable rate.
// - Transmit start by buffer write, start bit or external trigger.
// - Reception begins on a start bit only while receive enabled.
// - Frame completion sets done flags that can raise interrupts.
// - Done flags set and stay readable with interrupts masked.
// - Hardware detects break condition and synch byte.
// - Synch pattern edges go to a timer channel for rate matching.
//
// Implementation choices: the APB register port and the placing of the registers.
module serial_port
    import serial_port_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic RX_I,
    input wire logic TX_TRIG_I,
    output logic TX_O,
    output logic SYNC_EDGE_O,
    output logic IRQ_O
);

    typedef enum {TX_IDLE, TX_SHIFT} tx_state_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

    function automatic logic known_ofs(input logic [ADDR_W-1:0] a);
        known_ofs = (a == TX_BUFFER_OFS) || (a == RX_BUFFER_OFS) || (a == CTRL_OFS) ||
                    (a == BAUD_OFS) || (a == STATUS_OFS) || (a == MASK_OFS) ||
                    (a == STATE_OFS);
    endfunction : known_ofs

    ctrl_s ctrl_r;
    logic [23:0] baud_r;
    logic [EV_W-1:0] status_r, mask_r, ev_set;
    logic [DATA_W-1:0] tx_hold_r, rx_buf_r, rx_word;
    logic tx_full_r, tx_armed_r, tx_go, tx_end;
    logic [10:0] tx_sr_r;
    logic [3:0] tx_tick_r, tx_bits_r, rx_tick_r, rx_bits_r;
    logic [DATA_W-1:0] rx_sr_r;
    logic rx_meta_r, rx_sync_r, rx_prev_r, rx_fall, rx_load, brk_seen_r;
    logic [15:0] baud_cnt_r, div_int, reload;
    logic [7:0] frac_acc_r, div_frac;
    logic [8:0] frac_sum;
    logic tick;
    logic [31:0] prdata_r;
    logic wr, setup, wr_tx, wr_ctrl, brk_ev, synch_ev;
    tx_state_e tx_state_r;
    rx_state_e rx_state_r;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = PSEL_I && !PENABLE_I;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && known_ofs(PADDR_I);
    assign wr_tx = wr && (PADDR_I == TX_BUFFER_OFS);
    assign wr_ctrl = wr && (PADDR_I == CTRL_OFS);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !known_ofs(PADDR_I);
    assign PRDATA_O = prdata_r;

    // Read data captured in setup so it comes from a flip-flop
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            prdata_r <= 32'h0;
        end else if (setup && !PWRITE_I) begin
            case (PADDR_I)
                TX_BUFFER_OFS: prdata_r <= {23'h0, tx_hold_r};
                RX_BUFFER_OFS: prdata_r <= {23'h0, rx_buf_r};
                CTRL_OFS: prdata_r <= {26'h0, ctrl_r};
                BAUD_OFS: prdata_r <= {8'h0, baud_r};
                STATUS_OFS: prdata_r <= {28'h0, status_r};
                MASK_OFS: prdata_r <= {28'h0, mask_r};
                STATE_OFS: prdata_r <= {28'h0, brk_seen_r, tx_full_r,
                                        rx_state_r != RX_IDLE, tx_state_r != TX_IDLE};
                default: prdata_r <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_r <= ctrl_s'(CTRL_RESET);
            baud_r <= BAUD_RESET;
            mask_r <= EV_RESET;
        end else if (wr) begin
            if (PADDR_I == CTRL_OFS) ctrl_r <= ctrl_s'(PWDATA_I[CTRL_W-1:0]);
            if (PADDR_I == BAUD_OFS) baud_r <= PWDATA_I[23:0];
            if (PADDR_I == MASK_OFS) mask_r <= PWDATA_I[EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign ev_set = {synch_ev, brk_ev, rx_load, tx_end};

    // Flags set regardless of mask; set beats write-one clear
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            status_r <= EV_RESET;
        end else if (wr && (PADDR_I == STATUS_OFS)) begin
            status_r <= (status_r & ~PWDATA_I[EV_W-1:0]) | ev_set;
        end else begin
            status_r <= status_r | ev_set;
        end
    end

    // Unmasked done flags request an interrupt
    assign IRQ_O = |(status_r & mask_r);

    // ------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------
    // Fixed rate or programmable integer plus 1/256 fraction
    assign div_int = ctrl_r.var_baud ? baud_r[15:0] : FIXED_DIV_INT;
    assign div_frac = ctrl_r.var_baud ? baud_r[BAUD_FRAC_LSB +: 8] : FIXED_DIV_FRAC;
    assign frac_sum = {1'b0, frac_acc_r} + {1'b0, div_frac};
    // Divider of zero behaves as one so the tick never stalls
    assign reload = ((div_int == 16'h0) ? 16'h1 : div_int) + {15'h0, frac_sum[8]} - 16'h1;
    assign tick = (baud_cnt_r == 16'h0);

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            baud_cnt_r <= 16'h0;
            frac_acc_r <= 8'h0;
        end else if (tick) begin
            baud_cnt_r <= reload;
            frac_acc_r <= frac_sum[7:0];
        end else begin
            baud_cnt_r <= baud_cnt_r - 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    // Start source chosen in control
    assign tx_go = (tx_state_r == TX_IDLE) && tx_full_r &&
                   ((ctrl_r.start_src == START_ON_WRITE) || tx_armed_r);
    assign tx_end = (tx_state_r == TX_SHIFT) && tick && (tx_tick_r == TICK_LAST) &&
                    (tx_bits_r == 4'h1);

    // Holding register is free again once the shifter takes it
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_hold_r <= 9'h0;
            tx_full_r <= 1'b0;
        end else if (wr_tx) begin
            tx_hold_r <= PWDATA_I[DATA_W-1:0];
            tx_full_r <= 1'b1;
        end else if (tx_go) begin
            tx_full_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_armed_r <= 1'b0;
        end else if ((wr_ctrl && PWDATA_I[CTRL_START_BIT] &&
                      (ctrl_r.start_src == START_ON_BIT)) ||
                     (TX_TRIG_I && (ctrl_r.start_src == START_ON_TRIG))) begin
            tx_armed_r <= 1'b1;
        end else if (tx_go) begin
            tx_armed_r <= 1'b0;
        end
    end

    // Own shifter and state, no sharing with the receiver
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_state_r <= TX_IDLE;
            tx_sr_r <= 11'h7ff;
            tx_tick_r <= 4'h0;
            tx_bits_r <= 4'h0;
        end else begin
            case (tx_state_r)
                TX_IDLE: begin
                    if (tx_go) begin
                        // Start low, stop high, LSB next to start
                        tx_sr_r <= {1'b1, ctrl_r.nine_bit ? tx_hold_r[8] : 1'b1,
                                    tx_hold_r[7:0], 1'b0};
                        tx_bits_r <= ctrl_r.nine_bit ? BITS_9 : BITS_8;
                        tx_tick_r <= 4'h0;
                        tx_state_r <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        tx_tick_r <= tx_tick_r + 4'h1;
                        if (tx_tick_r == TICK_LAST) begin
                            tx_sr_r <= {1'b1, tx_sr_r[10:1]};
                            tx_bits_r <= tx_bits_r - 4'h1;
                            if (tx_bits_r == 4'h1) tx_state_r <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            TX_O <= 1'b1;
        end else begin
            // Output inverter flips idle and data levels
            TX_O <= ((tx_state_r == TX_SHIFT) ? tx_sr_r[0] : 1'b1) ^ ctrl_r.tx_invert;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= RX_I;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    assign rx_fall = rx_prev_r && !rx_sync_r;
    assign rx_word = ctrl_r.nine_bit ? rx_sr_r : {1'b0, rx_sr_r[8:1]};
    // Break shows as all-zero data with a low stop bit
    assign brk_ev = (rx_state_r == RX_STOP) && tick && (rx_tick_r == TICK_LAST) &&
                    !rx_sync_r && (rx_word == 9'h0);
    assign rx_load = (rx_state_r == RX_STOP) && tick && (rx_tick_r == TICK_LAST) &&
                     rx_sync_r;
    assign synch_ev = rx_load && brk_seen_r && (rx_word[7:0] == SYNCH_BYTE);

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_state_r <= RX_IDLE;
            rx_tick_r <= 4'h0;
            rx_bits_r <= 4'h0;
            rx_sr_r <= 9'h0;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    // Start bit accepted only while enabled
                    if (rx_fall && ctrl_r.rx_enable) begin
                        rx_state_r <= RX_START;
                        rx_tick_r <= 4'h0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        rx_tick_r <= rx_tick_r + 4'h1;
                        // Glitch shorter than half a bit is dropped
                        if (rx_tick_r == TICK_MID) begin
                            rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
                            rx_tick_r <= 4'h0;
                            rx_bits_r <= ctrl_r.nine_bit ? DATA_BITS_9 : DATA_BITS_8;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        rx_tick_r <= rx_tick_r + 4'h1;
                        if (rx_tick_r == TICK_LAST) begin
                            // LSB first, shifted in from the top
                            rx_sr_r <= {rx_sync_r, rx_sr_r[8:1]};
                            rx_bits_r <= rx_bits_r - 4'h1;
                            if (rx_bits_r == 4'h1) rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        rx_tick_r <= rx_tick_r + 4'h1;
                        if (rx_tick_r == TICK_LAST) rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // Buffer independent of shifter; unread byte overwritten
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_buf_r <= 9'h0;
        end else if (rx_load) begin
            rx_buf_r <= rx_word;
        end
    end

    // Break arms synch search, next good frame ends it
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            brk_seen_r <= 1'b0;
        end else if (brk_ev) begin
            brk_seen_r <= 1'b1;
        end else if (rx_load) begin
            brk_seen_r <= 1'b0;
        end
    end

    // Falling edges of the synch pattern for timer capture
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            SYNC_EDGE_O <= 1'b0;
        end else begin
            SYNC_EDGE_O <= rx_fall && brk_seen_r;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);

    sequence tx_buffer_write_s;
        PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == TX_BUFFER_OFS);
    endsequence
    sequence tx_begin_s;
        (tx_state_r == TX_IDLE) ##1 (tx_state_r == TX_SHIFT);
    endsequence

    tx_hold_load_a: assert property (tx_buffer_write_s |=>
        tx_full_r && (tx_hold_r == $past(PWDATA_I[DATA_W-1:0])))
        else $error("holding register not loaded");
    tx_start_low_a: assert property (tx_begin_s |=>
        (TX_O == ctrl_r.tx_invert))
        else $error("start bit level wrong");
    tx_idle_high_a: assert property ((tx_state_r == TX_IDLE) && $stable(ctrl_r) |=>
        (TX_O == !$past(ctrl_r.tx_invert)))
        else $error("idle line level wrong");
    tx_done_flag_a: assert property (tx_end |=>
        status_r[EV_TX_DONE] && (tx_state_r == TX_IDLE))
        else $error("transmit done flag not set");
    rx_enable_gate_a: assert property ((rx_state_r == RX_IDLE) && !ctrl_r.rx_enable |=>
        (rx_state_r == RX_IDLE))
        else $error("reception started while disabled");
    rx_overwrite_a: assert property (rx_load |=>
        (rx_buf_r == $past(rx_word)) && status_r[EV_RX_DONE])
        else $error("received byte not stored");
    irq_masked_a: assert property (!mask_r[EV_RX_DONE] && !mask_r[EV_TX_DONE] && rx_load &&
        !(|(status_r & mask_r)) |=> status_r[EV_RX_DONE] && !IRQ_O)
        else $error("masked flag wrong");
    break_flag_a: assert property (brk_ev |=> brk_seen_r && status_r[EV_BREAK])
        else $error("break not flagged");
    tx_frame_len_a: assert property (tx_begin_s |=>
        (tx_bits_r == (ctrl_r.nine_bit ? BITS_9 : BITS_8)))
        else $error("frame length wrong");

endmodule : serial_port

// ---- serial_port_pkg.sv ----
// Constants, register map and field layouts of the asynchronous serial port
package serial_port_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the APB
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] TX_BUFFER_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] RX_BUFFER_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] BAUD_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] STATE_OFS = 8'h18;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int CTRL_W = 6;
    localparam int CTRL_START_BIT = 6;
    localparam int BAUD_FRAC_LSB = 16;
    localparam int EV_W = 4;
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_DONE = 1;
    localparam int EV_BREAK = 2;
    localparam int EV_SYNCH = 3;
    localparam logic [7:0] SYNCH_BYTE = 8'h55;

    typedef enum logic [1:0] {
        START_ON_WRITE,
        START_ON_BIT,
        START_ON_TRIG,
        START_RSVD
    } start_src_e;

    // Layout of the control register, high bits first down to rx_enable
    typedef struct packed {
        logic var_baud;
        logic tx_invert;
        logic nine_bit;
        start_src_e start_src;
        logic rx_enable;
    } ctrl_s;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;

    // ------------------------------------------------------------
    // Bit timing: 16 ticks per bit, divider in 1/256 steps
    // ------------------------------------------------------------
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam longint CLK_HZ = 100000000;
    localparam longint FIXED_BAUD = 115200;
    localparam longint FIXED_DIV_X256 = (CLK_HZ * 256) / (OVERSAMPLE * FIXED_BAUD);
    localparam logic [15:0] FIXED_DIV_INT = 16'(FIXED_DIV_X256 >> 8);
    localparam logic [7:0] FIXED_DIV_FRAC = 8'(FIXED_DIV_X256);
    localparam logic [23:0] BAUD_RESET = {FIXED_DIV_FRAC, FIXED_DIV_INT};
    localparam logic [3:0] BITS_8 = 4'ha;
    localparam logic [3:0] BITS_9 = 4'hb;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;

endpackage : serial_port_pkg

// ---- serial_remote.sv ----
// Remote asynchronous node: drives the receive line, decodes the transmit line
module serial_remote (
    input wire logic clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int bit_cyc = 16;
    logic inv = 1'b0;
    logic nine = 1'b0;
    logic [9:0] got_q[$];
    int got_n = 0;

    initial rx_line_o = 1'b1;

    // ----
    // Sender
    // ----
    // start, data LSB first, stop, idle
    task automatic send(input logic [8:0] d, input logic stop);
        rx_line_o <= 1'b0;
        repeat (bit_cyc) @(posedge clk_i);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            rx_line_o <= d[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        rx_line_o <= stop;
        repeat (bit_cyc) @(posedge clk_i);
        rx_line_o <= 1'b1;
        repeat (bit_cyc) @(posedge clk_i);
    endtask : send

    // ----
    // Receiver
    // ----
    // start low, LSB first, stop kept
    initial begin
        logic [9:0] w;
        forever begin
            @(posedge clk_i iff (tx_line_i ^ inv) === 1'b0);
            repeat (bit_cyc / 2) @(posedge clk_i);
            // Half-bit recheck drops glitches from polarity changes
            if ((tx_line_i ^ inv) === 1'b0) begin
                w = '0;
                for (int i = 0; i < (nine ? 10 : 9); i++) begin
                    repeat (bit_cyc) @(posedge clk_i);
                    w[i] = tx_line_i ^ inv;
                end
                if (!nine) begin
                    w = {w[8], 1'b0, w[7:0]};
                end
                got_q.push_back(w);
                got_n++;
            end
        end
    end
endmodule : serial_remote

// ---- test_async_serial_port_lin_capable.sv ----
// Self-checking bench of the serial port with a remote node model
module test_async_serial_port_lin_capable
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic trig = 1'b0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, rx, tx, sedge, irq, err;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'hf0c64c25;
    int edges = 0;

    serial_port dut (.CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .TX_TRIG_I(trig), .TX_O(tx),
        .SYNC_EDGE_O(sedge), .IRQ_O(irq));
    serial_remote rem (.clk_i(clk), .tx_line_i(tx), .rx_line_o(rx));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (sedge === 1'b1) begin
            edges <= edges + 1;
        end
    end

    // ----
    // Tasks
    // ----
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Word the remote reports: stop at bit 9, bit 8 only in nine-bit frames
    function automatic logic [31:0] frame_exp(input logic [8:0] d, input logic nine);
        frame_exp = {22'h0, 1'b1, nine ? d : {1'b0, d[7:0]}};
    endfunction : frame_exp

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            chk("pready", 1, 0);
            stop_test();
        end
        @(posedge clk);
    endtask : apb

    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (rem.got_n < n && k < 20000) begin
            @(posedge clk);
            k++;
        end
        if (rem.got_n < n) begin
            chk("frame", 1, 0);
            stop_test();
        end
    endtask : wait_got

    // ----
    // Main sequence
    // ----
    initial begin
        logic [8:0] b0, b1, b2, m;
        int g;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("tx idle", 1, 32'(tx));
        apb(BAUD_OFS, 1'b0, 0);
        chk("baud rst", {8'h0, BAUD_RESET}, q);
        apb(MASK_OFS, 1'b0, 0);
        chk("mask rst", 0, q);
        apb(8'h1c, 1'b1, 32'hffffffff);
        chk("unmapped err", 1, 32'(err));
        apb(8'h1c, 1'b0, 0);
        chk("unmapped rd", 0, q);
        // Fixed rate after reset: 16 ticks of 54.25 cycles per bit
        rem.bit_cyc = int'(FIXED_DIV_X256) * 16 / 256;
        b0 = 9'($random(seed));
        apb(TX_BUFFER_OFS, 1'b1, {23'h0, b0});
        wait_got(1);
        chk("fixed rate", frame_exp(b0, 1'b0), 32'(rem.got_q.pop_front()));
        apb(BAUD_OFS, 1'b1, 32'h1);
        apb(CTRL_OFS, 1'b1, 32'h20);
        // Old fixed-rate count must run out before the fast tick starts
        repeat (60) @(posedge clk);
        rem.bit_cyc = 16;
        for (int c = 0; c < 4; c++) begin
            rem.nine = c[0];
            rem.inv = c[1];
            m = c[0] ? 9'h1ff : 9'h0ff;
            apb(CTRL_OFS, 1'b1, {26'h0, 1'b1, c[1], c[0], 3'h1});
            @(posedge clk);
            chk("idle level", 32'(!c[1]), 32'(tx));
            apb(STATUS_OFS, 1'b1, 32'hf);
            b0 = 9'($random(seed));
            b1 = 9'($random(seed));
            b2 = 9'($random(seed));
            g = rem.got_n;
            fork
                rem.send(b2, 1'b1);
                begin
                    apb(TX_BUFFER_OFS, 1'b1, {23'h0, b0});
                    apb(TX_BUFFER_OFS, 1'b1, {23'h0, b1});
                    wait_got(g + 2);
                end
            join
            chk("tx first", frame_exp(b0, c[0]), 32'(rem.got_q.pop_front()));
            chk("tx second", frame_exp(b1, c[0]), 32'(rem.got_q.pop_front()));
            apb(STATUS_OFS, 1'b0, 0);
            chk("done flags", 32'h3, q);
            chk("irq off", 0, 32'(irq));
            apb(RX_BUFFER_OFS, 1'b0, 0);
            chk("rx byte", {23'h0, b2 & m}, {23'h0, q[8:0] & m});
        end
        rem.nine = 1'b0;
        rem.inv = 1'b0;
        for (int s = 1; s < 3; s++) begin
            apb(CTRL_OFS, 1'b1, {26'h0, 1'b1, 2'h0, s[1:0], 1'b1});
            b0 = 9'($random(seed));
            g = rem.got_n;
            apb(TX_BUFFER_OFS, 1'b1, {23'h0, b0});
            apb(STATE_OFS, 1'b0, 0);
            chk("held", 32'h4, {29'h0, q[2:0]});
            if (s == 1) begin
                apb(CTRL_OFS, 1'b1, 32'h63);
            end else begin
                trig <= 1'b1;
                @(posedge clk);
                trig <= 1'b0;
            end
            wait_got(g + 1);
            chk("src frame", frame_exp(b0, 1'b0), 32'(rem.got_q.pop_front()));
        end
        apb(CTRL_OFS, 1'b1, 32'h20);
        // Last frame's stop bit ends before the flags are cleared
        repeat (20) @(posedge clk);
        apb(STATUS_OFS, 1'b1, 32'hf);
        rem.send(9'($random(seed)), 1'b1);
        apb(STATUS_OFS, 1'b0, 0);
        chk("rx off", 0, q);
        apb(CTRL_OFS, 1'b1, 32'h21);
        b0 = 9'($random(seed));
        b1 = 9'($random(seed));
        rem.send(b0, 1'b1);
        rem.send(b1, 1'b1);
        apb(RX_BUFFER_OFS, 1'b0, 0);
        chk("overwrite", {24'h0, b1[7:0]}, {24'h0, q[7:0]});
        chk("irq masked", 0, 32'(irq));
        apb(MASK_OFS, 1'b1, 32'h2);
        chk("irq up", 1, 32'(irq));
        apb(STATUS_OFS, 1'b1, 32'h2);
        chk("irq clear", 0, 32'(irq));
        apb(STATUS_OFS, 1'b1, 32'hf);
        rem.send(9'h000, 1'b0);
        apb(STATUS_OFS, 1'b0, 0);
        chk("break", 32'h4, q);
        g = edges;
        rem.send({1'b0, SYNCH_BYTE}, 1'b1);
        apb(STATUS_OFS, 1'b0, 0);
        chk("synch", 32'he, q);
        chk("synch edges", 5, 32'(edges - g));
        stop_test();
    end
endmodule : test_async_serial_port_lin_capable
